// ---- adpm_consts.svh ----
// Register map, field positions, reset values and masks of the playback DMA and mixer block
// Functional notes
// - Each mixer volume holds 5-bit left and right gains, 00000 loudest, 11111 quietest.
// - Bit 15 mutes the path; mute and gains are read/write, other bits reserved.
// - Recording source field picks primary ADC, synth, serial, PCM or secondary ADC.
// - Playback control bit 0 reads 1 when the playback queue is empty.
// - Bits 1 and 2 mark buffer I or buffer II as the last transfer.
// - Bits 4 to 3 select rate converter output rate: 48, 44.1 or 32 kHz.
// - Writing 1 to bit 5 starts playback; writing 0 commands a stop.
// - After a stop with bit 7 at 0 the current buffer finishes before bus requests cease; a stop on a non-last buffer's final beat runs the next buffer too.
// - On overrun the newest data overwrites the oldest queued data.
// - Bit 6 pauses the transfer while bit 5 stays 1; clearing resumes.
// - Bit 7 chooses stop at buffer end (0) or immediate stop (1).
// - Bits 11 to 8 hold the sampling rate code, 5.5 kHz to 48 kHz.
// - Bits 13 to 12 select two, four, six or alternate six channel layout.
// - Multichannel samples run L, R, LS, RS, then centre and LFE.
// - Bit 14 selects 8-bit unsigned or 16-bit signed; bit 15 mono or stereo.
// - One length serves both buffers; each buffer moves the length plus one.
// - Reading the length returns the remaining count once playback started.
// - Buffer address registers take the start address, read back the current address.
// - Control bits 15 to 5 and 2 to 1 are read/write, bit 0 read-only.
// - Capture control mirrors playback except bit 0 is read/write and bit 12 read-only; bits 4 to 3 input rate, bit 13 bypass.
`ifndef ADPM_CONSTS_SVH
`define ADPM_CONSTS_SVH

// ==========================================================
// Byte offsets
`define ADPM_OFS_PCM_VOL 8'h00
`define ADPM_OFS_SYN_VOL 8'h02
`define ADPM_OFS_SER_VOL 8'h04
`define ADPM_OFS_REC_SRC 8'h06
`define ADPM_OFS_PB_CTRL 8'h08
`define ADPM_OFS_PB_LEN 8'h0a
`define ADPM_OFS_PB_BUF1 8'h0c
`define ADPM_OFS_PB_BUF2 8'h10
`define ADPM_OFS_CAP_CTRL 8'h14
`define ADPM_OFS_CAP_LEN 8'h16
`define ADPM_OFS_CAP_BUF1 8'h18
`define ADPM_OFS_CAP_BUF2 8'h1c

// ==========================================================
// Reset values and writable masks
`define ADPM_RST_VOL 16'h8808
`define ADPM_RST_REC 8'h00
`define ADPM_RST_CTRL 16'hca00
`define ADPM_RST_LEN 16'hffff
`define ADPM_RST_ADDR 32'h0000ffff
`define ADPM_WM_VOL 16'h9f1f
`define ADPM_WM_REC 8'h07
`define ADPM_WM_PB_CTRL 16'hffe6
`define ADPM_WM_CAP_CTRL 16'hefe7

// ==========================================================
// Field positions
`define ADPM_VOL_MUTE 15
`define ADPM_CTL_EMPTY 0
`define ADPM_CTL_LAST1 1
`define ADPM_CTL_LAST2 2
`define ADPM_CTL_CONV_LSB 3
`define ADPM_CTL_ACT 5
`define ADPM_CTL_PAUSE 6
`define ADPM_CTL_STOPPT 7
`define ADPM_CTL_RATE_LSB 8
`define ADPM_CTL_CHFMT_LSB 12
`define ADPM_CTL_BYPASS 13
`define ADPM_CTL_FMT16 14
`define ADPM_CTL_STEREO 15
`define ADPM_ADDR_STEP 32'h00000004

`endif

// ---- adpm_pkg.sv ----
// Types and helpers shared by the playback DMA and mixer block
`default_nettype none
package adpm_pkg;

	typedef enum logic [1:0] {
		ADPM_IDLE = 2'b00,
		ADPM_RUN = 2'b01,
		ADPM_HALT = 2'b10
	} adpm_eng_t;

	typedef enum logic [1:0] {
		ADPM_M_IDLE = 2'b00,
		ADPM_M_REQ = 2'b01,
		ADPM_M_WAIT = 2'b10,
		ADPM_M_PUSH = 2'b11
	} adpm_mst_t;

	// Merge the written byte lanes of one half-word into an old 16-bit value
	function automatic logic [15:0] adpm_wr16(input logic [15:0] old, input logic [31:0] wd,
		input logic [3:0] be, input logic hi);
		logic [15:0] d;
		logic [1:0] b;
		d = hi ? wd[31:16] : wd[15:0];
		b = hi ? be[3:2] : be[1:0];
		return {b[1] ? d[15:8] : old[15:8], b[0] ? d[7:0] : old[7:0]};
	endfunction

	function automatic logic [31:0] adpm_wr32(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		return {adpm_wr16(old[31:16], wd, be, 1'b1), adpm_wr16(old[15:0], wd, be, 1'b0)};
	endfunction

	function automatic logic [15:0] adpm_mask16(input logic [15:0] old, input logic [15:0] nw,
		input logic [15:0] wm);
		return (nw & wm) | (old & ~wm);
	endfunction

endpackage
`default_nettype wire

// ---- adpm_strm_if.sv ----
// Word stream between the bus master and the playback queue
`default_nettype none
interface adpm_strm_if #(parameter int W = 32);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ---- adpm_fifo.sv ----
// Playback queue: overwrite-on-overrun FIFO
`default_nettype none
module adpm_fifo #(
	parameter int W = 32,
	parameter int DEPTH = 8
) (
	input wire logic clk_i,
	input wire logic srst_i,
	adpm_strm_if.snk in_s,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [W-1:0] out_data_o,
	output logic empty_o
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [CW-1:0] cnt;
	} adpm_fifo_st_t;

	adpm_fifo_st_t s_ff, nxt_s;
	logic full;
	logic push;
	logic pop;

	assign full = (s_ff.cnt == CW'(DEPTH));
	assign empty_o = (s_ff.cnt == '0);
	assign out_valid_o = !empty_o;
	assign out_data_o = s_ff.mem[s_ff.rp];
	// Ready tells the source to stop issuing; a word already fetched still lands
	assign in_s.ready = !full;
	assign push = in_s.valid;
	assign pop = out_ready_i && !empty_o;

	always_comb begin
		nxt_s = s_ff;
		if (push) begin
			nxt_s.mem[s_ff.wp] = in_s.data;
			nxt_s.wp = s_ff.wp + AW'(1);
		end
		if (push && full && !pop) begin
			nxt_s.rp = s_ff.rp + AW'(1);
		end else begin
			if (pop) begin
				nxt_s.rp = s_ff.rp + AW'(1);
			end
			if (push && !pop) begin
				nxt_s.cnt = s_ff.cnt + CW'(1);
			end else if (pop && !push) begin
				nxt_s.cnt = s_ff.cnt - CW'(1);
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			nxt_s_rst: begin
				s_ff <= '0;
			end
		end else begin
			s_ff <= nxt_s;
		end
	end
endmodule // adpm_fifo
`default_nettype wire

// ---- adpm_master.sv ----
// Single-beat bus-master read unit
`default_nettype none
module adpm_master
	import adpm_pkg::*;
(
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic issue_i,
	input wire logic [31:0] addr_i,
	output logic busy_o,
	output logic done_o,
	output logic mem_req_o,
	output logic [31:0] mem_addr_o,
	input wire logic mem_gnt_i,
	input wire logic mem_rvalid_i,
	input wire logic [31:0] mem_rdata_i,
	adpm_strm_if.src push_s
);
	typedef struct packed {
		adpm_mst_t st;
		logic [31:0] addr;
		logic [31:0] data;
	} adpm_mst_st_t;

	adpm_mst_st_t s_ff, nxt_s;

	assign busy_o = (s_ff.st != ADPM_M_IDLE);
	assign done_o = (s_ff.st == ADPM_M_PUSH);
	assign mem_req_o = (s_ff.st == ADPM_M_REQ);
	assign mem_addr_o = s_ff.addr;
	assign push_s.valid = (s_ff.st == ADPM_M_PUSH);
	assign push_s.data = s_ff.data;

	always_comb begin
		nxt_s = s_ff;
		case (s_ff.st)
			ADPM_M_IDLE: begin
				if (issue_i) begin
					nxt_s.addr = addr_i;
					nxt_s.st = ADPM_M_REQ;
				end
			end
			ADPM_M_REQ: begin
				if (mem_gnt_i) begin
					nxt_s.st = ADPM_M_WAIT;
				end
			end
			ADPM_M_WAIT: begin
				if (mem_rvalid_i) begin
					nxt_s.data = mem_rdata_i;
					nxt_s.st = ADPM_M_PUSH;
				end
			end
			default: begin
				// Host data cannot be held back, so the push is never stalled
				nxt_s.st = ADPM_M_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			s_ff <= '{st: ADPM_M_IDLE, addr: 32'h0, data: 32'h0};
		end else begin
			s_ff <= nxt_s;
		end
	end
endmodule // adpm_master
`default_nettype wire

// ---- adpm_dma_top.sv ----
// Playback DMA channel, mixer volume and capture control registers
`include "adpm_consts.svh"
`default_nettype none
module adpm_dma_top
	import adpm_pkg::*;
#(
	parameter int FIFO_DEPTH = 8
) (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [3:0] reg_be_i,
	input wire logic [31:0] reg_wdata_i,
	output logic [31:0] reg_rdata_o,
	output logic reg_rvalid_o,
	output logic mem_req_o,
	output logic [31:0] mem_addr_o,
	input wire logic mem_gnt_i,
	input wire logic mem_rvalid_i,
	input wire logic [31:0] mem_rdata_i,
	output logic smp_valid_o,
	input wire logic smp_ready_i,
	output logic [31:0] smp_data_o,
	output logic [15:0] pcm_vol_o,
	output logic [15:0] synth_vol_o,
	output logic [15:0] serial_vol_o,
	output logic [2:0] rec_src_o,
	output logic [1:0] pb_conv_rate_o,
	output logic [3:0] pb_smp_rate_o,
	output logic [1:0] pb_chan_fmt_o,
	output logic pb_fmt16_o,
	output logic pb_stereo_o,
	output logic pb_active_o,
	output logic [1:0] cap_conv_rate_o,
	output logic cap_bypass_o
);
	// ==========================================================
	// State
	typedef struct packed {
		logic [15:0] pcm_vol;
		logic [15:0] syn_vol;
		logic [15:0] ser_vol;
		logic [7:0] rec_src;
		logic [15:0] pb_ctrl;
		logic [15:0] pb_len;
		logic [15:0] pb_rem;
		logic [31:0] start1;
		logic [31:0] start2;
		logic [31:0] cur1;
		logic [31:0] cur2;
		logic [15:0] cap_ctrl;
		logic [15:0] cap_len;
		logic [31:0] cap_b1;
		logic [31:0] cap_b2;
		adpm_eng_t st;
		logic sel;
		logic stop_pend;
		logic started;
		logic [31:0] rdata;
		logic rvalid;
	} adpm_top_st_t;

	adpm_top_st_t s_ff, nxt_s;

	adpm_strm_if #(.W(32)) strm ();

	logic m_busy;
	logic m_done;
	logic issue;
	logic [31:0] issue_addr;
	logic q_empty;
	logic [5:0] dw;
	logic [15:0] ctl_new;
	logic buf_last;

	assign dw = reg_addr_i[7:2];

	// ==========================================================
	// Sub-blocks
	adpm_master u_master (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.issue_i(issue),
		.addr_i(issue_addr),
		.busy_o(m_busy),
		.done_o(m_done),
		.mem_req_o(mem_req_o),
		.mem_addr_o(mem_addr_o),
		.mem_gnt_i(mem_gnt_i),
		.mem_rvalid_i(mem_rvalid_i),
		.mem_rdata_i(mem_rdata_i),
		.push_s(strm.src)
	);

	// Words pass through in memory order, so channel interleave is kept as fetched
	adpm_fifo #(.W(32), .DEPTH(FIFO_DEPTH)) u_queue (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.in_s(strm.snk),
		.out_valid_o(smp_valid_o),
		.out_ready_i(smp_ready_i),
		.out_data_o(smp_data_o),
		.empty_o(q_empty)
	);

	// ==========================================================
	// Engine issue
	// Only one read is outstanding, so queue room at issue guarantees a slot
	assign issue_addr = s_ff.sel ? s_ff.cur2 : s_ff.cur1;
	assign issue = (s_ff.st == ADPM_RUN) && !s_ff.pb_ctrl[`ADPM_CTL_PAUSE] &&
		!m_busy && strm.ready;
	assign buf_last = s_ff.sel ? s_ff.pb_ctrl[`ADPM_CTL_LAST2] : s_ff.pb_ctrl[`ADPM_CTL_LAST1];
	assign ctl_new = adpm_mask16(s_ff.pb_ctrl, adpm_wr16(s_ff.pb_ctrl, reg_wdata_i, reg_be_i,
		1'b0), `ADPM_WM_PB_CTRL);

	always_comb begin
		nxt_s = s_ff;
		nxt_s.rvalid = reg_rd_i;

		// ==========================================================
		// Beat accounting
		if (m_done) begin
			if (s_ff.sel) begin
				nxt_s.cur2 = s_ff.cur2 + `ADPM_ADDR_STEP;
			end else begin
				nxt_s.cur1 = s_ff.cur1 + `ADPM_ADDR_STEP;
			end
			if (s_ff.pb_rem != 16'h0) begin
				nxt_s.pb_rem = s_ff.pb_rem - 16'h1;
			end else if (buf_last || s_ff.stop_pend || s_ff.st != ADPM_RUN) begin
				nxt_s.st = ADPM_IDLE;
				nxt_s.stop_pend = 1'b0;
			end else begin
				nxt_s.sel = !s_ff.sel;
				if (s_ff.sel) begin
					nxt_s.cur1 = s_ff.start1;
				end else begin
					nxt_s.cur2 = s_ff.start2;
				end
				nxt_s.pb_rem = s_ff.pb_len;
			end
		end
		if (s_ff.st == ADPM_HALT && !m_busy) begin
			nxt_s.st = ADPM_IDLE;
			nxt_s.stop_pend = 1'b0;
		end

		// ==========================================================
		// Host writes
		if (reg_wr_i) begin
			if (dw == `ADPM_OFS_PCM_VOL >> 2) begin
				nxt_s.pcm_vol = adpm_mask16(s_ff.pcm_vol, adpm_wr16(s_ff.pcm_vol, reg_wdata_i,
					reg_be_i, 1'b0), `ADPM_WM_VOL);
				nxt_s.syn_vol = adpm_mask16(s_ff.syn_vol, adpm_wr16(s_ff.syn_vol, reg_wdata_i,
					reg_be_i, 1'b1), `ADPM_WM_VOL);
			end else if (dw == `ADPM_OFS_SER_VOL >> 2) begin
				nxt_s.ser_vol = adpm_mask16(s_ff.ser_vol, adpm_wr16(s_ff.ser_vol, reg_wdata_i,
					reg_be_i, 1'b0), `ADPM_WM_VOL);
				if (reg_be_i[2]) begin
					nxt_s.rec_src = reg_wdata_i[23:16] & `ADPM_WM_REC;
				end
			end else if (dw == `ADPM_OFS_PB_CTRL >> 2) begin
				nxt_s.pb_ctrl = ctl_new;
				if (reg_be_i[0]) begin
					if (ctl_new[`ADPM_CTL_ACT]) begin
						if (s_ff.st == ADPM_IDLE) begin
							nxt_s.st = ADPM_RUN;
							nxt_s.sel = 1'b0;
							nxt_s.cur1 = s_ff.start1;
							nxt_s.pb_rem = s_ff.pb_len;
							nxt_s.started = 1'b1;
						end
						nxt_s.stop_pend = 1'b0;
					end else if (s_ff.st == ADPM_RUN) begin
						// A buffer-end stop (bit 7 at 0) that lands on the final beat of a buffer not marked last ends only after the next buffer
						if (ctl_new[`ADPM_CTL_STOPPT]) begin
							nxt_s.st = ADPM_HALT;
						end else if (nxt_s.st == ADPM_RUN) begin
							nxt_s.stop_pend = 1'b1;
						end
					end
				end
				if (reg_be_i[3:2] != 2'b00) begin
					nxt_s.pb_len = adpm_wr16(s_ff.pb_len, reg_wdata_i, reg_be_i, 1'b1);
				end
			end else if (dw == `ADPM_OFS_PB_BUF1 >> 2) begin
				nxt_s.start1 = adpm_wr32(s_ff.start1, reg_wdata_i, reg_be_i);
				nxt_s.cur1 = adpm_wr32(s_ff.cur1, reg_wdata_i, reg_be_i);
			end else if (dw == `ADPM_OFS_PB_BUF2 >> 2) begin
				nxt_s.start2 = adpm_wr32(s_ff.start2, reg_wdata_i, reg_be_i);
				nxt_s.cur2 = adpm_wr32(s_ff.cur2, reg_wdata_i, reg_be_i);
			end else if (dw == `ADPM_OFS_CAP_CTRL >> 2) begin
				nxt_s.cap_ctrl = adpm_mask16(s_ff.cap_ctrl, adpm_wr16(s_ff.cap_ctrl, reg_wdata_i,
					reg_be_i, 1'b0), `ADPM_WM_CAP_CTRL);
				nxt_s.cap_len = adpm_wr16(s_ff.cap_len, reg_wdata_i, reg_be_i, 1'b1);
			end else if (dw == `ADPM_OFS_CAP_BUF1 >> 2) begin
				nxt_s.cap_b1 = adpm_wr32(s_ff.cap_b1, reg_wdata_i, reg_be_i);
			end else if (dw == `ADPM_OFS_CAP_BUF2 >> 2) begin
				nxt_s.cap_b2 = adpm_wr32(s_ff.cap_b2, reg_wdata_i, reg_be_i);
			end
		end

		// ==========================================================
		// Host reads
		if (reg_rd_i) begin
			if (dw == `ADPM_OFS_PCM_VOL >> 2) begin
				nxt_s.rdata = {s_ff.syn_vol, s_ff.pcm_vol};
			end else if (dw == `ADPM_OFS_SER_VOL >> 2) begin
				nxt_s.rdata = {8'h00, s_ff.rec_src, s_ff.ser_vol};
			end else if (dw == `ADPM_OFS_PB_CTRL >> 2) begin
				nxt_s.rdata = {s_ff.started ? s_ff.pb_rem : s_ff.pb_len,
					s_ff.pb_ctrl[15:1], q_empty};
			end else if (dw == `ADPM_OFS_PB_BUF1 >> 2) begin
				nxt_s.rdata = s_ff.cur1;
			end else if (dw == `ADPM_OFS_PB_BUF2 >> 2) begin
				nxt_s.rdata = s_ff.cur2;
			end else if (dw == `ADPM_OFS_CAP_CTRL >> 2) begin
				nxt_s.rdata = {s_ff.cap_len, s_ff.cap_ctrl};
			end else if (dw == `ADPM_OFS_CAP_BUF1 >> 2) begin
				nxt_s.rdata = s_ff.cap_b1;
			end else if (dw == `ADPM_OFS_CAP_BUF2 >> 2) begin
				nxt_s.rdata = s_ff.cap_b2;
			end else begin
				nxt_s.rdata = 32'h0;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			s_ff <= '{pcm_vol: `ADPM_RST_VOL, syn_vol: `ADPM_RST_VOL, ser_vol: `ADPM_RST_VOL,
				rec_src: `ADPM_RST_REC, pb_ctrl: `ADPM_RST_CTRL, pb_len: `ADPM_RST_LEN,
				pb_rem: `ADPM_RST_LEN, start1: `ADPM_RST_ADDR, start2: `ADPM_RST_ADDR,
				cur1: `ADPM_RST_ADDR, cur2: `ADPM_RST_ADDR, cap_ctrl: `ADPM_RST_CTRL,
				cap_len: `ADPM_RST_LEN, cap_b1: `ADPM_RST_ADDR, cap_b2: `ADPM_RST_ADDR,
				st: ADPM_IDLE, sel: 1'b0, stop_pend: 1'b0, started: 1'b0, rdata: 32'h0,
				rvalid: 1'b0};
		end else begin
			s_ff <= nxt_s;
		end
	end

	// ==========================================================
	// Outputs
	assign reg_rdata_o = s_ff.rdata;
	assign reg_rvalid_o = s_ff.rvalid;
	assign pcm_vol_o = s_ff.pcm_vol;
	assign synth_vol_o = s_ff.syn_vol;
	assign serial_vol_o = s_ff.ser_vol;
	assign rec_src_o = s_ff.rec_src[2:0];
	assign pb_conv_rate_o = s_ff.pb_ctrl[`ADPM_CTL_CONV_LSB +: 2];
	assign pb_smp_rate_o = s_ff.pb_ctrl[`ADPM_CTL_RATE_LSB +: 4];
	assign pb_chan_fmt_o = s_ff.pb_ctrl[`ADPM_CTL_CHFMT_LSB +: 2];
	assign pb_fmt16_o = s_ff.pb_ctrl[`ADPM_CTL_FMT16];
	assign pb_stereo_o = s_ff.pb_ctrl[`ADPM_CTL_STEREO];
	assign pb_active_o = (s_ff.st != ADPM_IDLE);
	assign cap_conv_rate_o = s_ff.cap_ctrl[`ADPM_CTL_CONV_LSB +: 2];
	assign cap_bypass_o = s_ff.cap_ctrl[`ADPM_CTL_BYPASS];
endmodule // adpm_dma_top
`default_nettype wire

// ---- adpm_dma_top_properties.sv ----
// Port checker for the playback DMA and mixer block
`default_nettype none
module adpm_dma_top_props (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [3:0] reg_be_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic [31:0] reg_rdata_o,
	input wire logic mem_req_o,
	input wire logic [31:0] mem_addr_o,
	input wire logic mem_gnt_i,
	input wire logic smp_valid_o,
	input wire logic [15:0] pcm_vol_o,
	input wire logic [15:0] synth_vol_o,
	input wire logic [15:0] serial_vol_o,
	input wire logic [1:0] pb_chan_fmt_o,
	input wire logic pb_fmt16_o,
	input wire logic [1:0] cap_conv_rate_o,
	input wire logic [2:0] rec_src_o,
	input wire logic [1:0] pb_conv_rate_o,
	input wire logic [3:0] pb_smp_rate_o,
	input wire logic pb_stereo_o,
	input wire logic pb_active_o,
	input wire logic cap_bypass_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (srst_i);
	// ==========================================================
	// Register writes
	wire w0 = reg_wr_i && reg_addr_i[7:2] == 6'd0;
	wire w1 = reg_wr_i && reg_addr_i[7:2] == 6'd1;
	wire w2 = reg_wr_i && reg_addr_i[7:2] == 6'd2;
	wire w5 = reg_wr_i && reg_addr_i[7:2] == 6'd5;
	a_pcm_gain_write: assert property (
		w0 && reg_be_i[1:0] == 2'b11 |=> pcm_vol_o == ($past(reg_wdata_i[15:0]) & 16'h9f1f))
		else $error("pcm volume not taken");
	a_other_gain_write: assert property (
		(w0 && reg_be_i[3:2] == 2'b11 |=> synth_vol_o == ($past(reg_wdata_i[31:16]) & 16'h9f1f))
		and (w1 && reg_be_i[1:0] == 2'b11
		|=> serial_vol_o == ($past(reg_wdata_i[15:0]) & 16'h9f1f)))
		else $error("synth or serial volume not taken");
	a_rec_source_write: assert property (
		w1 && reg_be_i[2] |=> rec_src_o == $past(reg_wdata_i[18:16]))
		else $error("record source not taken");
	// Converter rate bits sit outside the host-writable set of both control words
	a_conv_rate_write: assert property (
		(w2 && reg_be_i[0] |=> pb_conv_rate_o == $past(pb_conv_rate_o))
		and (w5 && reg_be_i[0] |=> cap_conv_rate_o == $past(cap_conv_rate_o)))
		else $error("converter rate changed by write");
	a_format_write: assert property (
		w2 && reg_be_i[1] |=> pb_chan_fmt_o == $past(reg_wdata_i[13:12])
		&& pb_fmt16_o == $past(reg_wdata_i[14]))
		else $error("channel or sample format not taken");
	a_rate_fields_write: assert property (
		w2 && reg_be_i[1] |=> pb_smp_rate_o == $past(reg_wdata_i[11:8])
		&& pb_stereo_o == $past(reg_wdata_i[15]))
		else $error("rate or stereo field not taken");
	a_bypass_write: assert property (
		w5 && reg_be_i[1] |=> cap_bypass_o == $past(reg_wdata_i[13]))
		else $error("capture bypass not taken");
	// ==========================================================
	// Engine
	a_empty_flag: assert property (
		reg_rd_i && reg_addr_i[7:2] == 6'd2 |=> reg_rdata_o[0] != $past(smp_valid_o))
		else $error("empty flag disagrees with queue");
	a_start_active: assert property (
		w2 && reg_be_i[0] && reg_wdata_i[5] && !pb_active_o |=> pb_active_o)
		else $error("start did not activate engine");
	// Bound covers the memory model's answer after grant; the grant itself waits a random, unbounded time
	a_stop_now: assert property (
		w2 && reg_be_i[0] && !reg_wdata_i[5] && reg_wdata_i[7] && pb_active_o
		|-> ##[1:12] !pb_active_o)
		else $error("immediate stop too slow");
	a_req_held: assert property (
		mem_req_o && !mem_gnt_i |=> mem_req_o && $stable(mem_addr_o))
		else $error("request dropped before grant");
	a_idle_quiet: assert property (
		!pb_active_o |-> !mem_req_o)
		else $error("request while idle");
endmodule // adpm_dma_top_props
bind adpm_dma_top adpm_dma_top_props u_props (.*);
`default_nettype wire

// ---- adpm_mem_model.sv ----
// Behavioural host memory answering single-beat reads
`default_nettype none
module adpm_mem_model (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic req_i,
	input wire logic [31:0] addr_i,
	output logic gnt_o,
	output logic rvalid_o,
	output logic [31:0] rdata_o
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [31:0] K = 32'hc3c30000;
	logic pend = 1'b0;
	logic [1:0] wt = 2'd0;
	logic [31:0] adr = 32'h0;
	initial begin
		gnt_o = 1'b0;
		rvalid_o = 1'b0;
		rdata_o = 32'h0;
	end
	always @(posedge clk_i) begin
		gnt_o <= 1'b0;
		rvalid_o <= 1'b0;
		// Bus not held after the beat, so a stale word cannot pass
		rdata_o <= ~rdata_o;
		if (srst_i) begin
			pend <= 1'b0;
		end else if (pend) begin
			if (wt == 2'd0) begin
				rvalid_o <= 1'b1;
				rdata_o <= adr ^ K;
				pend <= 1'b0;
			end else begin
				wt <= wt - 2'd1;
			end
		end else if (req_i && 1'($urandom)) begin
			gnt_o <= 1'b1;
			adr <= addr_i;
			pend <= 1'b1;
			wt <= 2'($urandom % 3);
		end
	end
endmodule // adpm_mem_model
`default_nettype wire

// ---- adpm_dma_top_test.sv ----
// Self-checking bench for the playback DMA and mixer block
`default_nettype none
`define CHK(n, e, g) begin n_tests++; if ((e) !== (g)) begin err_count++; \
	$display("MISMATCH %s exp %h got %h", n, e, g); end end
module adpm_dma_top_test;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [31:0] K = 32'hc3c30000;
	logic clk_i, srst_i, reg_wr_i, reg_rd_i, mem_gnt_i, mem_rvalid_i, smp_ready_i;
	logic reg_rvalid_o, mem_req_o, smp_valid_o, pb_active_o, rdy_en, rr;
	logic [7:0] reg_addr_i;
	logic [3:0] reg_be_i;
	logic [31:0] reg_wdata_i, reg_rdata_o, mem_addr_o, mem_rdata_i, smp_data_o, v, c, e, m;
	logic [31:0] rq[$], mq[$], sq[$];
	int err_count, n_tests;
	logic [31:0] rv [9] = '{32'h88088808, 32'h00008808, 32'hffffca01, 32'h0000ffff,
		32'h0000ffff, 32'hffffca00, 32'h0000ffff, 32'h0000ffff, 32'h0};
	adpm_dma_top dut (.clk_i(clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_be_i(reg_be_i),
		.reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
		.mem_req_o(mem_req_o), .mem_addr_o(mem_addr_o), .mem_gnt_i(mem_gnt_i),
		.mem_rvalid_i(mem_rvalid_i), .mem_rdata_i(mem_rdata_i), .smp_valid_o(smp_valid_o),
		.smp_ready_i(smp_ready_i), .smp_data_o(smp_data_o), .pcm_vol_o(), .synth_vol_o(),
		.serial_vol_o(), .rec_src_o(), .pb_conv_rate_o(), .pb_smp_rate_o(),
		.pb_chan_fmt_o(), .pb_fmt16_o(), .pb_stereo_o(), .pb_active_o(pb_active_o),
		.cap_conv_rate_o(), .cap_bypass_o());
	adpm_mem_model u_mem (.clk_i(clk_i), .srst_i(srst_i), .req_i(mem_req_o),
		.addr_i(mem_addr_o), .gnt_o(mem_gnt_i), .rvalid_o(mem_rvalid_i),
		.rdata_o(mem_rdata_i));
	// ==========================================================
	// Clock, consumer and result watcher
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end
	// Outputs are looked at mid-cycle, where they stand settled
	always @(negedge clk_i) begin
		rr = rdy_en & 1'($urandom);
		if (reg_rvalid_o) begin
			e = rq.pop_front();
			m = mq.pop_front();
			`CHK("rdata", e & m, reg_rdata_o & m)
		end
		// The head word seen now is the one taken at the next rising edge
		if (smp_valid_o && rr) `CHK("sample", sq.pop_front(), smp_data_o)
		smp_ready_i <= rr;
	end
	// ==========================================================
	// Tasks
	task automatic wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
		@(negedge clk_i);
		reg_addr_i = a;
		reg_be_i = b;
		reg_wdata_i = d;
		reg_wr_i = 1'b1;
		@(negedge clk_i);
		reg_wr_i = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] k);
		@(negedge clk_i);
		reg_addr_i = a;
		reg_rd_i = 1'b1;
		rq.push_back(x);
		mq.push_back(k);
		@(negedge clk_i);
		reg_rd_i = 1'b0;
	endtask
	task automatic expect_buf(input logic [31:0] a, input int n);
		for (int k = 0; k < n; k++) sq.push_back((a + 32'(4 * k)) ^ K);
	endtask
	task automatic wait_idle();
		repeat (600) if (pb_active_o) @(negedge clk_i);
		`CHK("active", 1'b0, pb_active_o)
	endtask
	task automatic drain();
		repeat (600) if (sq.size() != 0) @(negedge clk_i);
		repeat (4) @(negedge clk_i);
		`CHK("left", 0, sq.size())
	endtask
	task automatic stop_test();
		if (err_count == 0 && n_tests > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk_i);
		err_count++;
		stop_test();
	end
	// ==========================================================
	// Scenarios
	initial begin
		{reg_wr_i, reg_rd_i, rdy_en, reg_be_i} = '0;
		{reg_addr_i, reg_wdata_i, err_count, n_tests} = '0;
		srst_i = 1'b1;
		void'($urandom(32'ha126));
		repeat (5) @(negedge clk_i);
		srst_i = 1'b0;
		for (int i = 0; i < 9; i++) rd(8'(i * 4), rv[i], '1);
		for (int i = 0; i < 4; i++) begin
			v = $urandom;
			wr(8'h00, 4'hf, v);
			wr(8'h00, 4'h4, ~v);
			rd(8'h00, {v[31:24], ~v[23:16], v[15:0]} & 32'h9f1f9f1f, '1);
			wr(8'h04, 4'hf, v);
			rd(8'h04, v & 32'h00079f1f, '1);
			wr(8'h14, 4'hf, v);
			rd(8'h14, {v[31:16], v[15:0] & 16'hefe7}, '1);
			wr(8'h20, 4'hf, v);
			rd(8'h20, 32'h0, '1);
		end
		// Two buffers of three words, buffer II marked last
		rdy_en = 1'b1;
		wr(8'h0c, 4'hf, 32'h1000);
		wr(8'h10, 4'hf, 32'h2000);
		wr(8'h08, 4'hc, 32'h00020000);
		c = {16'h0, v[15:8], 8'h24};
		expect_buf(32'h1000, 3);
		expect_buf(32'h2000, 3);
		wr(8'h08, 4'h3, c);
		wait_idle();
		drain();
		rd(8'h0c, 32'h100c, '1);
		rd(8'h10, 32'h200c, '1);
		rd(8'h08, (c & 32'hffe6) | 32'h1, 32'hffff);
		// Consumer stalls: queue fills, then an immediate stop
		rdy_en = 1'b0;
		wr(8'h0c, 4'hf, 32'h4000);
		wr(8'h08, 4'hc, 32'h000f0000);
		wr(8'h08, 4'h1, 32'ha0);
		repeat (300) @(negedge clk_i);
		wr(8'h08, 4'h1, 32'h80);
		wait_idle();
		rd(8'h0c, 32'h4020, '1);
		rd(8'h08, 32'h0, 32'h1);
		expect_buf(32'h4000, 8);
		rdy_en = 1'b1;
		drain();
		rd(8'h08, 32'h1, 32'h1);
		// Start paused, resume, then stop at buffer end
		wr(8'h0c, 4'hf, 32'h6000);
		wr(8'h10, 4'hf, 32'h7000);
		wr(8'h08, 4'hc, 32'h00030000);
		wr(8'h08, 4'h1, 32'h78);
		repeat (20) begin
			@(negedge clk_i);
			`CHK("paused_req", 1'b0, mem_req_o)
		end
		wr(8'h08, 4'h1, 32'h20);
		wr(8'h08, 4'h1, 32'h00);
		expect_buf(32'h6000, 4);
		wait_idle();
		drain();
		rd(8'h0c, 32'h6010, '1);
		rd(8'h10, 32'h7000, '1);
		repeat (4) @(negedge clk_i);
		stop_test();
	end
endmodule // adpm_dma_top_test
`default_nettype wire
